// ==== bench/probe_latch_assertions.sv ====
// probe_latch_assertions.sv: port checks for the probe latch
// assumes a bind onto the probe_position_latch ports
`timescale 1ns/1ps
module probe_latch_checker
(
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic probe_input_one_in,
    input wire logic probe_input_two_in,
    input wire logic [3:0] control_mode_selector_in,
    input wire probe_latch_pkg::obj_req_s req_in,
    input wire logic [31:0] rdata_out,
    input wire logic rvalid_out,
    input wire logic [1:0] pulse_format_out,
    input wire logic [1:0] probe_level_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);
    // ************************************************************
    // access and level checks
    // ************************************************************
    chk_read_answer: assert property (req_in.rd |=> rvalid_out)
        else $error("read not answered");
    chk_answer_cause: assert property (rvalid_out |-> $past(req_in.rd))
        else $error("answer without read");
    chk_write_silent: assert property (req_in.wr && !req_in.rd |=> !rvalid_out)
        else $error("write answered");
    chk_unmapped_zero: assert property (req_in.rd && !(req_in.index inside {16'h2007, [16'h60B8:16'h60BD]})
        |=> rdata_out == 32'h0) else $error("unmapped read not zero");
    chk_format_load: assert property (req_in.wr && req_in.index == 16'h2007
        |=> pulse_format_out == $past(req_in.wdata[1:0])) else $error("format not loaded");
    chk_format_hold: assert property (!(req_in.wr && req_in.index == 16'h2007)
        |=> $stable(pulse_format_out)) else $error("format moved");
    chk_level_one: assert property (($stable(control_mode_selector_in) && $stable(probe_input_one_in)
        && $stable(pulse_format_out))[*5] |-> probe_level_out[0] == (probe_input_one_in
        ^ (control_mode_selector_in == 4'h9 && !pulse_format_out[0]))) else $error("probe one level");
    chk_level_two: assert property (($stable(control_mode_selector_in) && $stable(probe_input_two_in)
        && $stable(pulse_format_out))[*5] |-> probe_level_out[1] == (probe_input_two_in
        ^ (control_mode_selector_in == 4'h9 && !pulse_format_out[1]))) else $error("probe two level");
endmodule // probe_latch_checker

// ==== bench/probe_position_latch_test.sv ====
// probe_position_latch_test.sv: register-level test of the probe latch
// assumes sensor model and checker compiled first
`timescale 1ns/1ps
module probe_position_latch_test;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] mode = 4'h0;
    probe_latch_pkg::obj_req_s req = '0;
    logic p1, p2, rvalid;
    logic [31:0] pos, rdata;
    logic [1:0] fmt, lvl;
    int n_fail = 0;
    int checks_done = 0;
    probe_position_latch u_dut (.ref_clk_in(clk), .rstn_in(rstn), .probe_input_one_in(p1),
        .probe_input_two_in(p2), .control_mode_selector_in(mode), .position_in(pos), .req_in(req),
        .rdata_out(rdata), .rvalid_out(rvalid), .pulse_format_out(fmt), .probe_level_out(lvl));
    probe_sensor_model u_sens (.clk_in(clk), .probe_one_out(p1), .probe_two_out(p2), .position_out(pos));
    // clock
    initial
    begin
        forever #5 clk = ~clk;
    end
    // compare and count
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %s exp %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [15:0] idx, input logic [31:0] d);
        @(negedge clk) req = '{1'b1, 1'b0, idx, d};
        @(negedge clk) req = '0;
    endtask
    task automatic rd(input logic [15:0] idx, input logic [31:0] exp);
        @(negedge clk) req = '{1'b0, 1'b1, idx, 32'h0};
        @(negedge clk) req = '0;
        chk("rvalid", {31'h0, rvalid}, 32'h1);
        chk("rdata", rdata, exp);
    endtask
    task automatic complete_run;
        $display("checks %0d fails %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // main sequence
    initial
    begin
        repeat (8) @(negedge clk);
        rstn = 1'b1;
        rd(16'h2007, 32'h3);
        chk("fmt", {30'h0, fmt}, 32'h3);
        rd(16'h1234, 32'h0);
        wr(16'h60B9, 32'hFFFF);
        rd(16'h60B9, 32'h0);
        mode = 4'h9;
        wr(16'h60B8, 32'h3331);
        u_sens.hit(1'b0, 1'b1, 32'h100);
        u_sens.hit(1'b1, 1'b1, 32'h200);
        u_sens.hit(1'b0, 1'b0, 32'h110);
        u_sens.hit(1'b1, 1'b0, 32'h210);
        rd(16'h60BA, 32'h100);
        rd(16'h60BB, 32'h110);
        rd(16'h60BC, 32'h200);
        rd(16'h60BD, 32'h210);
        rd(16'h60B9, 32'h0707);
        u_sens.hit(1'b0, 1'b1, 32'h120);
        u_sens.hit(1'b1, 1'b1, 32'h220);
        rd(16'h60BA, 32'h100);
        rd(16'h60BC, 32'h220);
        wr(16'h60B8, 32'h3330);
        wr(16'h60B8, 32'h3331);
        u_sens.hit(1'b0, 1'b0, 32'h130);
        rd(16'h60BB, 32'h130);
        // every polarity code, probe one low and probe two high
        for (int p = 0; p < 4; p++)
        begin
            wr(16'h2007, 32'(p));
            repeat (6) @(negedge clk);
            chk("level", {30'h0, lvl}, {30'h0, p[1], ~p[0]});
        end
        mode = 4'h0;
        wr(16'h2007, 32'h1);
        repeat (6) @(negedge clk);
        rd(16'h2007, 32'h1);
        chk("fmt", {30'h0, fmt}, 32'h1);
        chk("level", {30'h0, lvl}, 32'h2);
        // mid-run reset: defaults return, captures cleared, rise edge gated off
        rstn = 1'b0;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        rd(16'h2007, 32'h3);
        rd(16'h60BC, 32'h0);
        mode = 4'h9;
        wr(16'h60B8, 32'h0021);
        u_sens.hit(1'b0, 1'b1, 32'h140);
        u_sens.hit(1'b0, 1'b0, 32'h150);
        u_sens.hit(1'b1, 1'b0, 32'h250);
        rd(16'h60BA, 32'h0);
        rd(16'h60BB, 32'h150);
        rd(16'h60BD, 32'h0);
        rd(16'h60B9, 32'h0005);
        chk("level", {30'h0, lvl}, 32'h0);
        complete_run;
    end
endmodule // probe_position_latch_test
bind probe_position_latch probe_latch_checker u_chk (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
    .probe_input_one_in(probe_input_one_in), .probe_input_two_in(probe_input_two_in),
    .control_mode_selector_in(control_mode_selector_in), .req_in(req_in), .rdata_out(rdata_out),
    .rvalid_out(rvalid_out), .pulse_format_out(pulse_format_out), .probe_level_out(probe_level_out));

// ==== bench/probe_sensor_model.sv ====
// probe_sensor_model.sv: probe sensors and feedback position source
// assumes the bench calls hit and drives nothing else here
`timescale 1ns/1ps
module probe_sensor_model
(
    input wire logic clk_in,
    output logic probe_one_out = 1'b0,
    output logic probe_two_out = 1'b0,
    output logic [31:0] position_out = 32'h0
);
    // move one probe line at a held position, then spoil the position
    task automatic hit(input logic two, input logic lvl, input logic [31:0] p);
        @(negedge clk_in) position_out = p;
        if (two)
            probe_two_out = lvl;
        else
            probe_one_out = lvl;
        repeat (6) @(negedge clk_in);
        position_out = ~p;
    endtask
endmodule // probe_sensor_model

// ==== verilog/probe_latch_map.svh ====
// probe_latch_map.svh: register indices, field positions, reset values
// assumes inclusion by bare name from the design file
`ifndef PROBE_LATCH_MAP_SVH
`define PROBE_LATCH_MAP_SVH

// ****************************************************************
// object indices
// ****************************************************************
`define IDX_POLARITY_PARAM 16'h2007
`define IDX_CONTROL 16'h60B8
`define IDX_STATUS 16'h60B9
`define IDX_P1_RISE_POS 16'h60BA
`define IDX_P1_FALL_POS 16'h60BB
`define IDX_P2_RISE_POS 16'h60BC
`define IDX_P2_FALL_POS 16'h60BD

// ****************************************************************
// reset values and field positions
// ****************************************************************
`define POLARITY_RESET 16'h0003
`define PROBE_MODE_NETWORK 4'h9
`define CTRL_ENABLE_BIT 0
`define CTRL_MODE_BIT 1
`define CTRL_RISE_BIT 4
`define CTRL_FALL_BIT 5
`define STAT_ENABLE_BIT 0
`define STAT_RISE_BIT 1
`define STAT_FALL_BIT 2
`define CHANNEL_STRIDE 8

`endif

// ==== verilog/probe_latch_pkg.sv ====
// probe_latch_pkg.sv: types shared by the probe latch
// assumes probe_latch_map.svh is on the include path
package probe_latch_pkg;
    // register access request from the dictionary side
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] index;
        logic [31:0] wdata;
    } obj_req_s;
    // per-channel edge event pair
    typedef struct packed {
        logic rise;
        logic fall;
    } edge_pair_s;
endpackage

// ==== verilog/probe_position_latch.sv ====
// probe_position_latch.sv: two-channel touch-probe position latch
// assumes position_in on ref_clk_in, probe pairs already made single ended
`timescale 1ns/1ps
`include "probe_latch_map.svh"

module probe_position_latch
(
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic probe_input_one_in,
    input wire logic probe_input_two_in,
    input wire logic [3:0] control_mode_selector_in,
    input wire logic [31:0] position_in,
    input wire probe_latch_pkg::obj_req_s req_in,
    output logic [31:0] rdata_out,
    output logic rvalid_out,
    output logic [1:0] pulse_format_out,
    output logic [1:0] probe_level_out
);

    // ****************************************************************
    // helpers
    // ****************************************************************
    // index decoding used by read and write paths
    function automatic logic is_index(input logic [15:0] idx, input logic [15:0] want);
        is_index = (idx == want);
    endfunction

    logic [15:0] polarity_param;
    logic [15:0] next_polarity_param;
    logic [15:0] control;
    logic [15:0] next_control;
    logic [1:0] pins;
    logic [2:0] sync [1:0];
    logic [2:0] next_sync [1:0];
    logic [1:0] level;
    logic [1:0] next_level;
    logic [1:0] invert;
    probe_latch_pkg::edge_pair_s ev [1:0];
    logic [15:0] status;
    logic [15:0] next_status;
    logic [31:0] pos [3:0];
    logic [31:0] next_pos [3:0];
    logic [31:0] next_rdata;
    logic next_rvalid;

    assign pins = {probe_input_two_in, probe_input_one_in};

    // ****************************************************************
    // parameter and control objects
    // ****************************************************************
    // host writes to the polarity parameter and probe control word
    always_comb
    begin
        next_polarity_param = polarity_param;
        next_control = control;
        if (req_in.wr && is_index(req_in.index, `IDX_POLARITY_PARAM))
        begin
            next_polarity_param = req_in.wdata[15:0];
        end
        if (req_in.wr && is_index(req_in.index, `IDX_CONTROL))
        begin
            next_control = req_in.wdata[15:0];
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            polarity_param <= `POLARITY_RESET;
            control <= 16'h0000;
        end
        else
        begin
            polarity_param <= next_polarity_param;
            control <= next_control;
        end
    end

    // inversion only in network mode; a set bit means no inversion
    always_comb
    begin
        if (control_mode_selector_in == `PROBE_MODE_NETWORK)
        begin
            invert = ~polarity_param[1:0];
        end
        else
        begin
            invert = 2'h0;
        end
    end

    // otherwise the field selects the command pulse format
    assign pulse_format_out = polarity_param[1:0];

    // ****************************************************************
    // per channel synchroniser, edge detect and latch
    // ****************************************************************
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++)
        begin : g_chan
            localparam int base = ch * `CHANNEL_STRIDE;
            logic en;
            logic cont;
            // three-stage sync; level moves only when stages two and three agree
            always_comb
            begin
                next_sync[ch] = {sync[ch][1:0], pins[ch]};
                next_level[ch] = level[ch];
                if (sync[ch][1] == sync[ch][2])
                begin
                    next_level[ch] = sync[ch][2] ^ invert[ch];
                end
            end
            assign ev[ch].rise = next_level[ch] & ~level[ch];
            assign ev[ch].fall = ~next_level[ch] & level[ch];
            assign en = control[base + `CTRL_ENABLE_BIT];
            assign cont = control[base + `CTRL_MODE_BIT];

            // status flags and captures; single mode stops after first hit
            always_comb
            begin
                next_status[base +: `CHANNEL_STRIDE] = status[base +: `CHANNEL_STRIDE];
                next_pos[2 * ch] = pos[2 * ch];
                next_pos[2 * ch + 1] = pos[2 * ch + 1];
                next_status[base + `STAT_ENABLE_BIT] = en;
                if (!en)
                begin
                    next_status[base + `STAT_RISE_BIT] = 1'b0; // rearm by disable
                    next_status[base + `STAT_FALL_BIT] = 1'b0;
                end
                else
                begin
                    if (ev[ch].rise && control[base + `CTRL_RISE_BIT]
                        && (cont || !status[base + `STAT_RISE_BIT]))
                    begin
                        next_pos[2 * ch] = position_in;
                        next_status[base + `STAT_RISE_BIT] = 1'b1;
                    end
                    if (ev[ch].fall && control[base + `CTRL_FALL_BIT]
                        && (cont || !status[base + `STAT_FALL_BIT]))
                    begin
                        next_pos[2 * ch + 1] = position_in;
                        next_status[base + `STAT_FALL_BIT] = 1'b1;
                    end
                end
            end

            always_ff @(posedge ref_clk_in or negedge rstn_in)
            begin
                if (!rstn_in)
                begin
                    sync[ch] <= 3'h0;
                    level[ch] <= 1'b0;
                    status[base +: `CHANNEL_STRIDE] <= 8'h00;
                    pos[2 * ch] <= 32'h00000000;
                    pos[2 * ch + 1] <= 32'h00000000;
                end
                else
                begin
                    sync[ch] <= next_sync[ch];
                    level[ch] <= next_level[ch];
                    status[base +: `CHANNEL_STRIDE] <= next_status[base +: `CHANNEL_STRIDE];
                    pos[2 * ch] <= next_pos[2 * ch];
                    pos[2 * ch + 1] <= next_pos[2 * ch + 1];
                end
            end
        end
    endgenerate

    assign probe_level_out = level;

    // ****************************************************************
    // read path
    // ****************************************************************
    // one-cycle registered read; unknown index reads zero
    always_comb
    begin
        next_rvalid = req_in.rd;
        next_rdata = 32'h00000000;
        if (req_in.rd)
        begin
            if (is_index(req_in.index, `IDX_POLARITY_PARAM)) next_rdata = {16'h0000, polarity_param};
            else if (is_index(req_in.index, `IDX_CONTROL)) next_rdata = {16'h0000, control};
            else if (is_index(req_in.index, `IDX_STATUS)) next_rdata = {16'h0000, status};
            else if (is_index(req_in.index, `IDX_P1_RISE_POS)) next_rdata = pos[0];
            else if (is_index(req_in.index, `IDX_P1_FALL_POS)) next_rdata = pos[1];
            else if (is_index(req_in.index, `IDX_P2_RISE_POS)) next_rdata = pos[2];
            else if (is_index(req_in.index, `IDX_P2_FALL_POS)) next_rdata = pos[3];
            else next_rdata = 32'h00000000;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            rdata_out <= 32'h00000000;
            rvalid_out <= 1'b0;
        end
        else
        begin
            rdata_out <= next_rdata;
            rvalid_out <= next_rvalid;
        end
    end

endmodule // probe_position_latch
